//--- rtl/dssc_pkg.sv
// Shared constants, types and register map of the strap, status and config block
package dssc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_SER_ADDR = 8'h00;
  localparam logic [7:0] IDX_DES_ADDR = 8'h01;
  localparam logic [7:0] IDX_SPREAD_CFG = 8'h02;
  localparam logic [7:0] IDX_MOD_CALIB = 8'h03;
  localparam logic [7:0] IDX_FAULT_LIMIT = 8'h0C;
  localparam logic [7:0] IDX_DEC_COUNT = 8'h0D;
  localparam logic [7:0] IDX_PRBS_COUNT = 8'h0E;
  localparam logic [7:0] IDX_STATUS = 8'h20;
  localparam logic [7:0] IDX_CONTROL = 8'h21;
  localparam logic [7:0] IDX_LOCK_TOP = 8'h1F;
  localparam int BYTE_SHIFT = 2;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions and reset values
  localparam int DES_LOCK_BIT = 0;
  localparam logic [1:0] SER_MID_BITS = 2'b00;
  localparam logic [1:0] DES_MID_BITS = 2'b01;
  localparam logic [1:0] SS_OFF = 2'b00;
  localparam logic [1:0] SS_ON = 2'b01;
  localparam logic [1:0] RANGE_AUTO = 2'b11;
  localparam logic AUDIO_RST = 1'b1;
  localparam logic [7:0] MOD_CALIB_RST = 8'h00;
  localparam logic [7:0] FAULT_LIMIT_RST = 8'h00;
  localparam logic [1:0] LEVEL_LOW = 2'b00;
  localparam logic [1:0] LEVEL_MID = 2'b01;
  localparam logic [1:0] LEVEL_HIGH = 2'b10;
  localparam int CTRL_PRBS_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // Lane modes and spread depth
  localparam logic [2:0] LANES_NARROW = 3'd3;
  localparam logic [2:0] LANES_WIDE = 3'd4;
  localparam logic [4:0] BITS_NARROW = 5'd21;
  localparam logic [4:0] BITS_WIDE = 5'd28;
  localparam int SPREAD_PERCENT = 2;

  ////////////////////////////////////////////////////////////////////////////////
  // Strap settle time after power-up or wake
  localparam int CLK_MHZ = 100;
  localparam int STRAP_SETTLE_NS = 100;
  localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_NS * CLK_MHZ + 999) / 1000;

  typedef struct packed {
    logic [1:0] addr_hi;
    logic [1:0] addr_lo;
    logic spread;
    logic rate_low;
  } dssc_strap_t;

  typedef struct packed {
    logic [1:0] spread_sel;
    logic reserved;
    logic sound_on;
    logic [1:0] pixel_clock_range;
    logic [1:0] serial_rate_range;
  } dssc_spread_cfg_t;

  typedef struct packed {
    logic [1:0] modulation_calib_mode;
    logic reserved;
    logic [4:0] sawtooth_divider;
  } dssc_mod_calib_t;

  typedef enum logic [1:0] {
    ST_DOWN,
    ST_SETTLE,
    ST_RUN
  } dssc_state_t;

endpackage : dssc_pkg

//--- rtl/dssc_top.sv
// Strap capture, lock and error pins, and the first configuration registers
// What this block does
// R1: Upper address strap sampled only at wake
// R2: Lock high only when PLLs and alignment good
// R3: Lock stays low while config link active
// R4: Lock and error released during power-down
// R5: Outside pattern test, error asserts when decode count exceeds limit
// R6: Error asserts on any pattern-test mismatch
// R7: Control-link or autostart mode; the select pin picks, the mode strap enables
// R8: Spread strap latched; high gives two-percent spread
// R9: Rate strap latched; high picks low clock range
// R10: Three lanes 21 bits, four lanes 28 bits
// R11: Both address registers at indices zero and one
// R12: Serializer address defaults from straps, LSB zero
// R13: Deserializer address defaults from straps
// R14: Config lock resets clear, registers stay writable
// R15: Spread field default follows spread strap
// R16: Audio on, both range fields automatic at reset
// R17: Modulation calibration register resets to zero
// R18: Decode fault limit resets to zero
// R19: Host holds power-down low to sleep
// R20: Defaults reload on power-up and every wake
// R21: Straps pass a synchronizer before capture
module dssc_top
  import dssc_pkg::*;
#(
  parameter int SETTLE_CYC = STRAP_SETTLE_CYC,
  parameter int COUNT_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic power_down_n,
  input wire logic [1:0] address_strap_hi,
  input wire logic [1:0] address_strap_lo,
  input wire logic spread_strap,
  input wire logic rate_range_strap,
  input wire logic link_mode_strap,
  input wire logic config_link_select,
  input wire logic four_lane_sel,
  input wire logic pll_locked,
  input wire logic word_aligned,
  input wire logic config_link_active,
  input wire logic decode_fault,
  input wire logic prbs_mismatch,
  output logic lock_o,
  output logic lock_oe_n,
  output logic err_n_o,
  output logic err_n_oe_n,
  output logic ctrl_link_mode,
  output logic autostart_mode,
  output logic spread_on,
  output logic [1:0] spread_sel,
  output logic rate_low_range,
  output logic [2:0] lane_count,
  output logic [4:0] lane_bits,
  output logic aux_ctrl_on
);

  // Refused at elaboration, so a bad build never reaches time zero
  if (SETTLE_CYC < 2 || SETTLE_CYC > 4096) begin : g_bad_settle
    $error("dssc_top: SETTLE_CYC out of range");
  end
  if (COUNT_W < 1 || COUNT_W > 8) begin : g_bad_count
    $error("dssc_top: COUNT_W must be 1 to 8");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronizers
  localparam int PINS_W = $bits(dssc_strap_t) + 8;
  logic [PINS_W-1:0] pins_raw;
  logic [PINS_W-1:0] pins_meta_r;
  logic [PINS_W-1:0] pins_sync_r;

  assign pins_raw = {address_strap_hi, address_strap_lo, spread_strap, rate_range_strap,
                     power_down_n, link_mode_strap, config_link_select, four_lane_sel,
                     pll_locked, word_aligned, config_link_active, 1'b0};

  // First stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_meta_r <= '0;
      pins_sync_r <= '0;
    end else begin
      pins_meta_r <= pins_raw; // [R21]
      pins_sync_r <= pins_meta_r;
    end
  end

  dssc_strap_t strap_sync;
  wire pd_n_s = pins_sync_r[7];
  wire mode_s = pins_sync_r[6];
  wire cds_s = pins_sync_r[5];
  wire wide_s = pins_sync_r[4];
  wire pll_s = pins_sync_r[3];
  wire align_s = pins_sync_r[2];
  wire cfg_link_s = pins_sync_r[1];
  assign strap_sync = pins_sync_r[PINS_W-1:8];

  ////////////////////////////////////////////////////////////////////////////////
  // Power sequencing
  localparam int SETTLE_W = $clog2(SETTLE_CYC + 1);
  localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(SETTLE_CYC - 1);
  dssc_state_t state_r;
  dssc_state_t state_nxt;
  logic [SETTLE_W-1:0] settle_r;
  logic [SETTLE_W-1:0] settle_nxt;
  wire settle_done = (settle_r == SETTLE_LAST);

  // Reset acts as power-up, so defaults load through the same path as a wake
  always_comb begin
    state_nxt = state_r;
    settle_nxt = settle_r;
    case (state_r)
      ST_DOWN: begin
        settle_nxt = '0;
        if (pd_n_s) begin
          state_nxt = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        settle_nxt = settle_r + SETTLE_W'(1);
        if (!pd_n_s) begin
          state_nxt = ST_DOWN;
        end else if (settle_done) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!pd_n_s) begin
          state_nxt = ST_DOWN;
        end
      end
      default: begin
        state_nxt = ST_DOWN;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_DOWN;
      settle_r <= '0;
    end else begin
      state_r <= state_nxt;
      settle_r <= settle_nxt;
    end
  end

  // One pulse when straps are stable and defaults reload
  wire wake_load = (state_r == ST_SETTLE) && settle_done && pd_n_s; // [R20]
  wire running = (state_r == ST_RUN);

  ////////////////////////////////////////////////////////////////////////////////
  // Strap latch
  dssc_strap_t strap_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_r <= '0;
    end else if (wake_load) begin
      strap_r <= strap_sync; // [R1] [R8] [R9]
    end
  end

  // Unused fourth code of a three-level strap is taken as high
  function automatic logic [1:0] level_of(input logic [1:0] code);
    level_of = (code > LEVEL_HIGH) ? LEVEL_HIGH : code;
  endfunction : level_of

  wire [1:0] lvl_hi = level_of(strap_sync.addr_hi);
  wire [1:0] lvl_lo = level_of(strap_sync.addr_lo);
  wire [1:0] addr_top = lvl_hi + 2'b01;
  wire [7:0] ser_addr_dflt = {addr_top, SER_MID_BITS, lvl_lo, 2'b00}; // [R12]
  wire [7:0] des_addr_dflt = {addr_top, DES_MID_BITS, lvl_lo, 2'b00}; // [R13]
  wire [1:0] ss_dflt = strap_sync.spread ? SS_ON : SS_OFF; // [R15]

  ////////////////////////////////////////////////////////////////////////////////
  // APB decode; one wait state per access
  wire [7:0] idx = paddr[BYTE_SHIFT+7:BYTE_SHIFT];
  wire addr_aligned = (paddr[BYTE_SHIFT-1:0] == '0);
  wire access = psel && penable;
  wire commit = access && pready;
  wire hit_ser = (idx == IDX_SER_ADDR);
  wire hit_des = (idx == IDX_DES_ADDR);
  wire hit_spr = (idx == IDX_SPREAD_CFG);
  wire hit_mod = (idx == IDX_MOD_CALIB);
  wire hit_lim = (idx == IDX_FAULT_LIMIT);
  wire hit_dec = (idx == IDX_DEC_COUNT);
  wire hit_prb = (idx == IDX_PRBS_COUNT);
  wire hit_sts = (idx == IDX_STATUS);
  wire hit_ctl = (idx == IDX_CONTROL);
  wire mapped = addr_aligned && (hit_ser || hit_des || hit_spr || hit_mod || hit_lim
                                 || hit_dec || hit_prb || hit_sts || hit_ctl);
  wire read_only = hit_dec || hit_prb || hit_sts;

  logic [7:0] ser_addr_r;
  logic [7:0] des_addr_r;
  dssc_spread_cfg_t spread_cfg_r;
  dssc_mod_calib_t mod_calib_r;
  logic [7:0] fault_limit_r;
  logic prbs_test_r;

  // Lock covers the low register window until the next wake
  wire cfg_locked = des_addr_r[DES_LOCK_BIT];
  wire in_lock_range = (idx <= IDX_LOCK_TOP);
  wire wr_blocked = cfg_locked && in_lock_range; // [R14]
  wire bad_access = !mapped || (pwrite && (read_only || wr_blocked));
  wire wr_ok = commit && pwrite && !bad_access && pstrb[0];
  wire rd_ok = commit && !pwrite && mapped;

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ser_addr_r <= '0;
      des_addr_r <= '0;
      spread_cfg_r <= '0;
      mod_calib_r <= '0;
      fault_limit_r <= '0;
      prbs_test_r <= 1'b0;
    end else if (wake_load) begin
      ser_addr_r <= ser_addr_dflt; // [R12] [R20]
      des_addr_r <= des_addr_dflt; // [R13] [R14]
      spread_cfg_r <= {ss_dflt, 1'b0, AUDIO_RST, RANGE_AUTO, RANGE_AUTO}; // [R15] [R16]
      mod_calib_r <= MOD_CALIB_RST; // [R17]
      fault_limit_r <= FAULT_LIMIT_RST; // [R18]
      prbs_test_r <= 1'b0;
    end else if (wr_ok) begin
      if (hit_ser) begin
        ser_addr_r <= {pwdata[7:1], 1'b0}; // [R11] [R12]
      end
      if (hit_des) begin
        des_addr_r <= pwdata[7:0]; // [R11]
      end
      if (hit_spr) begin
        spread_cfg_r <= {pwdata[7:6], 1'b0, pwdata[4:0]};
      end
      if (hit_mod) begin
        mod_calib_r <= {pwdata[7:6], 1'b0, pwdata[4:0]};
      end
      if (hit_lim) begin
        fault_limit_r <= pwdata[7:0];
      end
      if (hit_ctl) begin
        prbs_test_r <= pwdata[CTRL_PRBS_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Fault counters: decode faults and pattern mismatches
  // Saturate rather than wrap so a long burst never reads as few faults
  localparam logic [COUNT_W-1:0] COUNT_MAX = '1;
  wire [1:0] cnt_event = {prbs_mismatch && prbs_test_r, decode_fault && !prbs_test_r};
  wire [1:0] cnt_clear = {rd_ok && hit_prb, rd_ok && hit_dec};
  logic [COUNT_W-1:0] fault_cnt_r [2];

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_cnt
      wire inc = cnt_event[gi] && running;
      wire at_max = (fault_cnt_r[gi] == COUNT_MAX);
      // Event in the clearing cycle survives as a count of one
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          fault_cnt_r[gi] <= '0;
        end else if (wake_load) begin
          fault_cnt_r[gi] <= '0;
        end else if (cnt_clear[gi]) begin
          fault_cnt_r[gi] <= inc ? COUNT_W'(1) : '0;
        end else if (inc && !at_max) begin
          fault_cnt_r[gi] <= fault_cnt_r[gi] + COUNT_W'(1);
        end
      end
    end
  endgenerate

  wire [7:0] dec_count = 8'(fault_cnt_r[0]);
  wire [7:0] prbs_count = 8'(fault_cnt_r[1]);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin status
  wire lock_good = pll_s && align_s && !cfg_link_s; // [R2] [R3]
  wire dec_over = (dec_count > fault_limit_r); // [R5] [R18]
  wire prbs_hit = (prbs_count != 8'h00); // [R6]
  wire err_active = running && (prbs_test_r ? prbs_hit : dec_over); // [R5] [R6]
  wire lock_high = running && lock_good;
  wire wide_lanes = wide_s;

  // Open drain: pin data is low, the enable decides
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_o <= 1'b0;
      lock_oe_n <= 1'b1;
      err_n_o <= 1'b0;
      err_n_oe_n <= 1'b1;
    end else begin
      lock_o <= 1'b0;
      err_n_o <= 1'b0;
      // High level comes from the pullup, so lock high means released
      lock_oe_n <= !pd_n_s || lock_high; // [R2] [R3] [R4]
      err_n_oe_n <= !pd_n_s || !err_active; // [R4] [R5] [R6]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Mode, spread and lane outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_link_mode <= 1'b0;
      autostart_mode <= 1'b0;
      spread_on <= 1'b0;
      spread_sel <= SS_OFF;
      rate_low_range <= 1'b0;
      lane_count <= LANES_NARROW;
      lane_bits <= BITS_NARROW;
      aux_ctrl_on <= 1'b0;
    end else begin
      // Mode strap is read live; its meaning follows the select pin
      ctrl_link_mode <= cds_s && mode_s; // [R7]
      autostart_mode <= !cds_s && mode_s; // [R7]
      spread_on <= strap_r.spread; // [R8]
      spread_sel <= spread_cfg_r.spread_sel;
      rate_low_range <= strap_r.rate_low; // [R9]
      lane_count <= wide_lanes ? LANES_WIDE : LANES_NARROW; // [R10]
      lane_bits <= wide_lanes ? BITS_WIDE : BITS_NARROW; // [R10]
      aux_ctrl_on <= wide_lanes; // [R10]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read mux
  wire [7:0] status_word = {running, lock_good, err_active, strap_r.spread,
                            strap_r.rate_low, cds_s, mode_s, wide_lanes};
  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h0000_0000;
    if (hit_ser) begin
      rd_word[7:0] = ser_addr_r;
    end else if (hit_des) begin
      rd_word[7:0] = des_addr_r;
    end else if (hit_spr) begin
      rd_word[7:0] = spread_cfg_r;
    end else if (hit_mod) begin
      rd_word[7:0] = mod_calib_r;
    end else if (hit_lim) begin
      rd_word[7:0] = fault_limit_r;
    end else if (hit_dec) begin
      rd_word[7:0] = dec_count;
    end else if (hit_prb) begin
      rd_word[7:0] = prbs_count;
    end else if (hit_sts) begin
      rd_word[7:0] = status_word;
    end else if (hit_ctl) begin
      rd_word[CTRL_PRBS_BIT] = prbs_test_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB answer; pready rises on the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= access && !pready;
      pslverr <= access && !pready && bad_access;
      if (access && !pready && !pwrite && mapped) begin
        prdata <= rd_word;
      end else if (commit) begin
        prdata <= 32'h0000_0000;
      end
    end
  end

endmodule : dssc_top

//--- tb/dssc_top_properties.sv
// Port checker for the strap, status and config block
module dssc_top_properties
  import dssc_pkg::*;
#(
  parameter int SETTLE_CYC = STRAP_SETTLE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic power_down_n,
  input wire logic link_mode_strap,
  input wire logic config_link_select,
  input wire logic four_lane_sel,
  input wire logic pll_locked,
  input wire logic word_aligned,
  input wire logic config_link_active,
  input wire logic lock_o,
  input wire logic lock_oe_n,
  input wire logic err_n_o,
  input wire logic err_n_oe_n,
  input wire logic ctrl_link_mode,
  input wire logic autostart_mode,
  input wire logic spread_on,
  input wire logic rate_low_range,
  input wire logic [2:0] lane_count,
  input wire logic [4:0] lane_bits,
  input wire logic aux_ctrl_on
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] up_r;
  logic run;
  // Margin over settle plus sync lag; run is only a safe lower bound
  assign run = up_r > 8'(SETTLE_CYC + 8);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_r <= 8'h00;
    end else if (!power_down_n) begin
      up_r <= 8'h00;
    end else if (up_r != 8'hFF) begin
      up_r <= up_r + 8'h01;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  AST_APB_WAIT: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
    else $error("pready not on second access cycle");
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr outside answer");
  AST_RDATA_TOP: assert property (pready |-> prdata[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
  AST_OPEN_DRAIN: assert property (!lock_o && !err_n_o)
    else $error("pin data not low");
  AST_PD_RELEASE: assert property (!power_down_n [*4] |-> lock_oe_n && err_n_oe_n)
    else $error("pins driven in power-down");
  AST_LOCK_GOOD: assert property ((run && pll_locked && word_aligned &&
      !config_link_active) [*4] |-> lock_oe_n)
    else $error("lock low with good link");
  AST_LOCK_BAD: assert property ((run && !(pll_locked && word_aligned)) [*4] |-> !lock_oe_n)
    else $error("lock high with bad link");
  AST_LOCK_CFG: assert property ((run && config_link_active) [*4] |-> !lock_oe_n)
    else $error("lock high with config link");
  AST_MODE_CTRL: assert property ((config_link_select && link_mode_strap) [*4]
      |-> ctrl_link_mode && !autostart_mode)
    else $error("control-link mode wrong");
  AST_MODE_AUTO: assert property ((!config_link_select && link_mode_strap) [*4]
      |-> autostart_mode && !ctrl_link_mode)
    else $error("autostart mode wrong");
  AST_STRAP_HELD: assert property (run && $past(run)
      |-> $stable(spread_on) && $stable(rate_low_range))
    else $error("latched strap moved");
  AST_LANES: assert property ((run && four_lane_sel) [*4]
      |-> lane_count == LANES_WIDE && lane_bits == BITS_WIDE && aux_ctrl_on)
    else $error("wide lane mode wrong");
endmodule : dssc_top_properties

//--- tb/dssc_link_model.sv
// Link front end model: PLL and alignment status, error events, pin pull-ups
module dssc_link_model (
  input wire logic pclk,
  input wire logic lock_o,
  input wire logic lock_oe_n,
  input wire logic err_n_o,
  input wire logic err_n_oe_n,
  output logic pll_locked,
  output logic word_aligned,
  output logic config_link_active,
  output logic decode_fault,
  output logic prbs_mismatch,
  output logic lock_pin,
  output logic err_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pull-ups win whenever the block lets go of the pins
  assign lock_pin = lock_oe_n ? 1'b1 : lock_o;
  assign err_pin = err_n_oe_n ? 1'b1 : err_n_o;
  initial begin
    pll_locked = 1'b0;
    word_aligned = 1'b0;
    config_link_active = 1'b0;
    decode_fault = 1'b0;
    prbs_mismatch = 1'b0;
  end
  task automatic set_link(input logic pll, input logic algn, input logic cfg);
    @(posedge pclk);
    pll_locked <= pll;
    word_aligned <= algn;
    config_link_active <= cfg;
  endtask : set_link
  // One-cycle events with a gap, as the block counts every cycle an event is high
  task automatic pulse(input logic prbs, input int n);
    repeat (n) begin
      @(posedge pclk);
      decode_fault <= !prbs;
      prbs_mismatch <= prbs;
      @(posedge pclk);
      decode_fault <= 1'b0;
      prbs_mismatch <= 1'b0;
    end
  endtask : pulse
endmodule : dssc_link_model

//--- tb/tb_dssc_top.sv
// Self-checking bench for the strap, status and config block
module tb_dssc_top
  import dssc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, power_down_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  dssc_strap_t strap;
  logic link_mode_strap, config_link_select, four_lane_sel, pll_locked, word_aligned;
  logic config_link_active, decode_fault, prbs_mismatch, lock_pin, err_pin;
  logic lock_o, lock_oe_n, err_n_o, err_n_oe_n, ctrl_link_mode, autostart_mode;
  logic spread_on, rate_low_range, aux_ctrl_on;
  logic [1:0] spread_sel;
  logic [2:0] lane_count;
  logic [4:0] lane_bits;
  int mismatches, compares;
  always #5 pclk = ~pclk;
  dssc_top #(.SETTLE_CYC(2)) u_dssc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .power_down_n,
    .address_strap_hi(strap.addr_hi), .address_strap_lo(strap.addr_lo),
    .spread_strap(strap.spread), .rate_range_strap(strap.rate_low), .link_mode_strap,
    .config_link_select, .four_lane_sel, .pll_locked, .word_aligned, .config_link_active,
    .decode_fault, .prbs_mismatch, .lock_o, .lock_oe_n, .err_n_o, .err_n_oe_n,
    .ctrl_link_mode, .autostart_mode, .spread_on, .spread_sel, .rate_low_range,
    .lane_count, .lane_bits, .aux_ctrl_on);
  dssc_link_model u_dssc_link_model (.pclk, .lock_o, .lock_oe_n, .err_n_o, .err_n_oe_n,
    .pll_locked, .word_aligned, .config_link_active, .decode_fault, .prbs_mismatch,
    .lock_pin, .err_pin);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                     input logic [7:0] exp, input logic exp_err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h00_0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk(pready, 1'b1);
    if (pready !== 1'b1) begin
      finish_test();
    end
    if (!wr) chk(prdata, {24'h00_0000, exp});
    chk(pslverr, exp_err);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wake();
    @(posedge pclk);
    power_down_n <= 1'b0;
    repeat (6) @(posedge pclk);
    chk({lock_pin, err_pin, lock_oe_n, err_n_oe_n}, 4'hF);
    power_down_n <= 1'b1;
    repeat (20) @(posedge pclk);
  endtask : wake
  task automatic wait_err(input logic e);
    for (int i = 0; i < 12 && err_pin !== e; i++) @(posedge pclk);
    chk(err_pin, e);
    if (err_pin !== e) finish_test();
  endtask : wait_err
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_defaults();
    dssc_strap_t s [2];
    s[0] = '{LEVEL_LOW, LEVEL_LOW, 1'b0, 1'b0};
    s[1] = '{LEVEL_HIGH, LEVEL_MID, 1'b1, 1'b1};
    for (int i = 0; i < 2; i++) begin
      strap <= s[i];
      wake();
      // Straps move after wake; values must not follow
      strap <= ~s[i];
      apb(0, IDX_SER_ADDR, 0, {s[i].addr_hi + 2'd1, 2'b00, s[i].addr_lo, 2'b00}, 0);
      apb(0, IDX_DES_ADDR, 0, {s[i].addr_hi + 2'd1, 2'b01, s[i].addr_lo, 2'b00}, 0);
      apb(0, IDX_SPREAD_CFG, 0, {s[i].spread ? SS_ON : SS_OFF, 1'b0, AUDIO_RST,
          RANGE_AUTO, RANGE_AUTO}, 0);
      apb(0, IDX_MOD_CALIB, 0, MOD_CALIB_RST, 0);
      apb(0, IDX_FAULT_LIMIT, 0, FAULT_LIMIT_RST, 0);
      chk({spread_on, rate_low_range}, {s[i].spread, s[i].rate_low});
    end
    $display("t_defaults done");
  endtask : t_defaults
  task automatic t_regs();
    strap <= '{LEVEL_MID, LEVEL_HIGH, 1'b0, 1'b0};
    apb(1, IDX_SER_ADDR, 8'hA5, 0, 0);
    apb(0, IDX_SER_ADDR, 0, 8'hA4, 0);
    apb(1, IDX_SPREAD_CFG, 8'hFF, 0, 0);
    apb(0, IDX_SPREAD_CFG, 0, 8'hDF, 0);
    chk(spread_sel, 2'b11);
    apb(1, 8'h05, 8'h11, 0, 1);
    apb(1, IDX_DEC_COUNT, 8'h00, 0, 1);
    apb(1, IDX_DES_ADDR, 8'h61, 0, 0);
    apb(1, IDX_SER_ADDR, 8'h3C, 0, 1);
    apb(0, IDX_SER_ADDR, 0, 8'hA4, 0);
    apb(0, IDX_DES_ADDR, 0, 8'h61, 0);
    wake();
    apb(0, IDX_DES_ADDR, 0, 8'h98, 0);
    apb(0, IDX_SPREAD_CFG, 0, 8'h1F, 0);
    $display("t_regs done");
  endtask : t_regs
  task automatic lk(input logic p, input logic a, input logic c, input logic e);
    u_dssc_link_model.set_link(p, a, c);
    repeat (5) @(posedge pclk);
    chk({lock_pin, lock_oe_n}, {e, e});
  endtask : lk
  task automatic t_lock();
    lk(1, 1, 0, 1);
    lk(1, 1, 1, 0);
    lk(1, 0, 0, 0);
    lk(0, 1, 0, 0);
    lk(1, 1, 0, 1);
    wake();
    $display("t_lock done");
  endtask : t_lock
  task automatic t_err();
    wait_err(1);
    u_dssc_link_model.pulse(0, 1);
    wait_err(0);
    apb(0, IDX_DEC_COUNT, 0, 8'h01, 0);
    wait_err(1);
    apb(1, IDX_FAULT_LIMIT, 8'h02, 0, 0);
    u_dssc_link_model.pulse(0, 2);
    repeat (8) @(posedge pclk);
    chk(err_pin, 1'b1);
    u_dssc_link_model.pulse(0, 1);
    wait_err(0);
    apb(1, IDX_CONTROL, 8'h01, 0, 0);
    apb(0, IDX_CONTROL, 0, 8'h01, 0);
    wait_err(1);
    u_dssc_link_model.pulse(1, 1);
    wait_err(0);
    apb(0, IDX_PRBS_COUNT, 0, 8'h01, 0);
    $display("t_err done");
  endtask : t_err
  task automatic t_modes();
    for (int i = 0; i < 4; i++) begin
      @(posedge pclk);
      {config_link_select, link_mode_strap} <= i[1:0];
      four_lane_sel <= i[0];
      repeat (5) @(posedge pclk);
      chk({ctrl_link_mode, autostart_mode}, {i[1] & i[0], !i[1] & i[0]});
      chk({lane_count, lane_bits, aux_ctrl_on}, i[0] ? {LANES_WIDE, BITS_WIDE, 1'b1}
          : {LANES_NARROW, BITS_NARROW, 1'b0});
    end
    $display("t_modes done");
  endtask : t_modes
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hF;
    power_down_n = 1'b1;
    strap = '0;
    {link_mode_strap, config_link_select, four_lane_sel} = '0;
    mismatches = 0;
    compares = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (20) @(posedge pclk);
    t_defaults();
    t_regs();
    t_lock();
    t_err();
    t_modes();
    finish_test();
  end
endmodule : tb_dssc_top
bind dssc_top dssc_top_properties #(.SETTLE_CYC(SETTLE_CYC)) u_dssc_top_properties (
  .pclk, .presetn, .psel, .penable, .prdata, .pready, .pslverr, .power_down_n,
  .link_mode_strap, .config_link_select, .four_lane_sel, .pll_locked, .word_aligned,
  .config_link_active, .lock_o, .lock_oe_n, .err_n_o, .err_n_oe_n, .ctrl_link_mode,
  .autostart_mode, .spread_on, .rate_low_range, .lane_count, .lane_bits, .aux_ctrl_on);
